/* dsp_block.sv */
// Multiply/add block: four 18x18 multipliers with adder, accumulator and shift chains
//
// Overview of operation
// - Exactly one arithmetic mode is active for the whole block.
// - Simple mode drives each product straight to the output lanes.
// - A 36x36 product combines four 18x18 partial products with shifts.
// - In 36x36 width the input shift chains are disabled.
// - The product register serves as a pipeline stage of the wide multiply.
// - Accumulate mode uses only multipliers two and four, giving two accumulators.
// - Each accumulator is 52 bits: 36-bit product plus 16 headroom bits.
// - Accumulator load and overflow act only in accumulate mode.
// - Add/subtract select lets the accumulator subtract; overflow flags underflow too.
// - Two-multiplier adder adds or subtracts product pairs: two 18-bit or four 9-bit.
// - One subtracting and one adding pair form a complex product.
// - Four-multiplier adder sums the two first-stage adder results.
// - FIR: data shifts on chain A, coefficients load serially or in parallel on B.
// - One block forms a four-tap 18-bit FIR without external shift registers.
// - Wide 36x36 configuration only multiplies; no add or accumulate.
// - Shift-chain outputs leave the block to feed the next block.
// - Eight 18-bit interface lanes, two per 18x18 multiplier.
// - Control bus: clears, enables, two signs, two add/sub selects, two loads.
// - Eight 18-bit operands in, eight 18-bit product lanes out.
// - Multiplier controls take zero or one stage; adder controls up to two.
// - Sign select high means signed; product signed if either operand is.
// - Add/subtract select high adds, low subtracts.
// - Accumulator load replaces the sum with the current product.
// - Accumulator always registered; overflow registered each output-enabled cycle, not sticky.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_defines.svh"

module dsp_block (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Static configuration
   input wire dsp_pkg::mode_e mode,
   input wire dsp_pkg::width_e width,
   input wire logic in_reg_en,
   input wire logic in_shift,
   input wire logic coef_serial,
   input wire logic pipe_reg_en,
   input wire logic ctl_mult_stage,
   input wire logic [1:0] ctl_add_stages,
   // Control bus
   input wire logic sign_a,
   input wire logic sign_b,
   input wire logic [1:0] add_sub,
   input wire logic [1:0] acc_load,
   input wire logic [3:0] grp_clear,
   input wire logic [3:0] grp_enable,
   // Operands and shift chain inputs
   input wire logic [`NMUL-1:0][`DW-1:0] a_in,
   input wire logic [`NMUL-1:0][`DW-1:0] b_in,
   input wire logic [`DW-1:0] shift_in_a,
   input wire logic [`DW-1:0] shift_in_b,
   // Results
   output logic [`NLANE-1:0][`DW-1:0] product_output_lane,
   output logic [1:0] overflow,
   output logic [`DW-1:0] shift_out_a,
   output logic [`DW-1:0] shift_out_b
);
   import dsp_pkg::*;

   state_s st_reg;
   state_s st_next;

   // Full-precision 18x18 product; the extra top bit carries sign or zero
   function automatic logic [`PW-1:0] mul18(input logic [`DW-1:0] a, input logic [`DW-1:0] b,
                                           input logic sa, input logic sb);
      logic signed [`DW:0] x;
      logic signed [`DW:0] y;
      logic signed [2*`DW+1:0] p;
      x = {sa & a[`DW-1], a};
      y = {sb & b[`DW-1], b};
      p = x * y;
      return p[`PW-1:0];
   endfunction : mul18

   // Full-precision 9x9 product
   function automatic logic [`QW-1:0] mul9(input logic [`HW-1:0] a, input logic [`HW-1:0] b,
                                          input logic sa, input logic sb);
      logic signed [`HW:0] x;
      logic signed [`HW:0] y;
      logic signed [2*`HW+1:0] p;
      x = {sa & a[`HW-1], a};
      y = {sb & b[`HW-1], b};
      p = x * y;
      return p[`QW-1:0];
   endfunction : mul9

   // Accumulate step; returns overflow flag above the 52-bit result
   function automatic logic [`ACCW:0] acc_step(input logic [`ACCW-1:0] acc,
                                              input logic [`PW-1:0] p,
                                              input logic add, input logic sgn);
      logic [`ACCW:0] x;
      logic [`ACCW:0] y;
      logic [`ACCW:0] s;
      logic ovf;
      x = {sgn & acc[`ACCW-1], acc};
      y = {{(`ACCW+1-`PW){p[`PW-1]}}, p};
      s = add ? x + y : x - y;
      ovf = sgn ? (s[`ACCW] ^ s[`ACCW-1]) : s[`ACCW];
      return {ovf, s[`ACCW-1:0]};
   endfunction : acc_step

   logic shifting;
   logic sa_m;
   logic sb_m;
   logic [`CTLW-1:0] ctl_raw;
   logic [`CTLW-1:0] ctl_act;
   logic sgn;
   logic [`NMUL-1:0][`DW-1:0] a_op;
   logic [`NMUL-1:0][`DW-1:0] b_op;
   logic [`NMUL-1:0][`PW-1:0] pp_c;
   logic [2*`NMUL-1:0][`QW-1:0] hp_c;
   logic [`NMUL-1:0][`PW-1:0] pp_u;
   logic [2*`NMUL-1:0][`QW-1:0] hp_u;
   logic [4*`DW-1:0] wide;
   logic [1:0][`PW:0] s2;
   logic [`PW+1:0] s4;
   logic [3:0][`QW:0] s9;
   logic [1:0][`QW+1:0] s9q;
   logic [`NLANE*`DW-1:0] lv;
   logic [1:0][`ACCW-1:0] acc_n;
   logic [1:0] ovf_n;
   logic [`ACCW:0] step;
   logic eff_simple;

   // Whole next state in one place; clears win over enables, enables hold otherwise
   always_comb begin
      st_next = st_reg;
      shifting = in_shift && (width != W36);
      // Control delay lines: multiplier path one stage, adder path up to two
      ctl_raw = {sign_a, sign_b, add_sub, acc_load};
      sa_m = ctl_mult_stage ? st_reg.mctl_reg[1] : sign_a;
      sb_m = ctl_mult_stage ? st_reg.mctl_reg[0] : sign_b;
      if (ctl_add_stages == 2'h0) begin
         ctl_act = ctl_raw;
      end else if (ctl_add_stages == 2'h1) begin
         ctl_act = st_reg.actl_reg[0];
      end else begin
         ctl_act = st_reg.actl_reg[1];
      end
      sgn = ctl_act[5] | ctl_act[4];
      if (grp_clear[`G_CTL]) begin
         st_next.mctl_reg = '0;
         st_next.actl_reg = '0;
      end else if (grp_enable[`G_CTL]) begin
         st_next.mctl_reg = {sign_a, sign_b};
         st_next.actl_reg = {st_reg.actl_reg[0], ctl_raw};
      end
      // Input registers and shift chains; chain A is data, chain B coefficients
      for (int i = 0; i < `NMUL; i++) begin
         a_op[i] = (in_reg_en || shifting) ? st_reg.a_reg[i] : a_in[i];
         b_op[i] = (in_reg_en || shifting) ? st_reg.b_reg[i] : b_in[i];
      end
      if (grp_clear[`G_IN]) begin
         st_next.a_reg = '0;
         st_next.b_reg = '0;
      end else if (grp_enable[`G_IN]) begin
         for (int i = 0; i < `NMUL; i++) begin
            if (shifting) begin
               st_next.a_reg[i] = (i == 0) ? shift_in_a : st_reg.a_reg[i-1];
               if (coef_serial) begin
                  st_next.b_reg[i] = (i == 0) ? shift_in_b : st_reg.b_reg[i-1];
               end else begin
                  st_next.b_reg[i] = b_in[i];
               end
            end else begin
               st_next.a_reg[i] = a_in[i];
               st_next.b_reg[i] = b_in[i];
            end
         end
      end
      // Multipliers; in wide mode the four units form partial products of A1:A0 x B1:B0
      for (int i = 0; i < `NMUL; i++) begin
         pp_c[i] = mul18(a_op[i], b_op[i], sa_m, sb_m);
         hp_c[2*i] = mul9(a_op[i][`HW-1:0], b_op[i][`HW-1:0], sa_m, sb_m);
         hp_c[2*i+1] = mul9(a_op[i][`DW-1:`HW], b_op[i][`DW-1:`HW], sa_m, sb_m);
      end
      if (width == W36) begin
         pp_c[0] = mul18(a_op[0], b_op[0], 1'b0, 1'b0);
         pp_c[1] = mul18(a_op[1], b_op[0], sa_m, 1'b0);
         pp_c[2] = mul18(a_op[0], b_op[1], 1'b0, sb_m);
         pp_c[3] = mul18(a_op[1], b_op[1], sa_m, sb_m);
      end
      // Product register doubles as the wide multiply's pipeline stage
      pp_u = pipe_reg_en ? st_reg.pp_reg : pp_c;
      hp_u = pipe_reg_en ? st_reg.hp_reg : hp_c;
      if (grp_clear[`G_PIPE]) begin
         st_next.pp_reg = '0;
         st_next.hp_reg = '0;
      end else if (grp_enable[`G_PIPE]) begin
         st_next.pp_reg = pp_c;
         st_next.hp_reg = hp_c;
      end
      // Shift-and-add of the four partials into the 72-bit product
      wide = {36'h0, pp_u[0][2*`DW-1:0]}
           + {{(`DW-1){pp_u[1][`PW-1]}}, pp_u[1], 18'h0}
           + {{(`DW-1){pp_u[2][`PW-1]}}, pp_u[2], 18'h0}
           + {pp_u[3][2*`DW-1:0], 36'h0};
      // First-stage adders; low select subtracts the second product
      for (int k = 0; k < 2; k++) begin
         s2[k] = ctl_act[2+k] ? {pp_u[2*k][`PW-1], pp_u[2*k]} + {pp_u[2*k+1][`PW-1], pp_u[2*k+1]}
                              : {pp_u[2*k][`PW-1], pp_u[2*k]} - {pp_u[2*k+1][`PW-1], pp_u[2*k+1]};
      end
      for (int j = 0; j < 4; j++) begin
         s9[j] = ctl_act[2+j/2]
               ? {hp_u[(j/2)*4+j%2][`QW-1], hp_u[(j/2)*4+j%2]}
                 + {hp_u[(j/2)*4+j%2+2][`QW-1], hp_u[(j/2)*4+j%2+2]}
               : {hp_u[(j/2)*4+j%2][`QW-1], hp_u[(j/2)*4+j%2]}
                 - {hp_u[(j/2)*4+j%2+2][`QW-1], hp_u[(j/2)*4+j%2+2]};
      end
      // Summation stage over the two first-stage results
      s4 = {s2[0][`PW], s2[0]} + {s2[1][`PW], s2[1]};
      for (int k = 0; k < 2; k++) begin
         s9q[k] = {s9[2*k][`QW], s9[2*k]} + {s9[2*k+1][`QW], s9[2*k+1]};
      end
      // Accumulators on multipliers two and four only
      eff_simple = (mode == MODE_SIMPLE) || (width == W36);
      acc_n = st_reg.acc_reg;
      ovf_n = 2'h0;
      for (int k = 0; k < 2; k++) begin
         step = acc_step(st_reg.acc_reg[k], pp_u[2*k+1], ctl_act[2+k], sgn);
         if (!eff_simple && mode == MODE_ACC) begin
            if (ctl_act[k]) begin
               acc_n[k] = {{(`ACCW-`PW){pp_u[2*k+1][`PW-1]}}, pp_u[2*k+1]};
            end else begin
               acc_n[k] = step[`ACCW-1:0];
               ovf_n[k] = step[`ACCW];
            end
         end
      end
      // Output lane selection by mode and width
      lv = '0;
      if (eff_simple) begin
         if (width == W36) begin
            lv[4*`DW-1:0] = wide;
         end else begin
            for (int i = 0; i < `NMUL; i++) begin
               if (width == W18) begin
                  lv[i*2*`DW +: 2*`DW] = pp_u[i][2*`DW-1:0];
               end else begin
                  lv[2*i*`DW +: `DW] = hp_u[2*i][`DW-1:0];
                  lv[(2*i+1)*`DW +: `DW] = hp_u[2*i+1][`DW-1:0];
               end
            end
         end
      end else if (mode == MODE_ACC) begin
         lv[0 +: `ACCW] = acc_n[0];
         lv[4*`DW +: `ACCW] = acc_n[1];
      end else if (mode == MODE_ADD2) begin
         for (int k = 0; k < 2; k++) begin
            if (width == W18) begin
               lv[k*4*`DW +: 3*`DW] = {{(3*`DW-`PW-1){s2[k][`PW]}}, s2[k]};
            end else begin
               lv[(2*k)*2*`DW +: 2*`DW] = {{(2*`DW-`QW-1){s9[2*k][`QW]}}, s9[2*k]};
               lv[(2*k+1)*2*`DW +: 2*`DW] = {{(2*`DW-`QW-1){s9[2*k+1][`QW]}}, s9[2*k+1]};
            end
         end
      end else begin
         if (width == W18) begin
            lv[0 +: 3*`DW] = {{(3*`DW-`PW-2){s4[`PW+1]}}, s4};
         end else begin
            for (int k = 0; k < 2; k++) begin
               lv[k*4*`DW +: 2*`DW] = {{(2*`DW-`QW-2){s9q[k][`QW+1]}}, s9q[k]};
            end
         end
      end
      // Output and accumulator registers share the output control group
      if (grp_clear[`G_OUT]) begin
         st_next.acc_reg = '0;
         st_next.ovf_reg = '0;
         st_next.lane_reg = '0;
      end else if (grp_enable[`G_OUT]) begin
         st_next.acc_reg = acc_n;
         st_next.ovf_reg = ovf_n; // flag follows each step, held only while the output group enable is low
         st_next.lane_reg = lv;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state register
   assign product_output_lane = st_reg.lane_reg;
   assign overflow = st_reg.ovf_reg;
   assign shift_out_a = st_reg.a_reg[`NMUL-1];
   assign shift_out_b = st_reg.b_reg[`NMUL-1];

endmodule : dsp_block
`default_nettype wire

/* dsp_defines.svh */
// Width, count and group-index constants for the multiply/add block
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH
`define DW 18
`define HW 9
`define PW 37
`define QW 19
`define ACCW 52
`define NMUL 4
`define NLANE 8
`define CTLW 6
`define G_IN 0
`define G_PIPE 1
`define G_OUT 2
`define G_CTL 3
`endif

/* dsp_pkg.sv */
// Types shared by the multiply/add block: modes, operand widths, state record
`include "dsp_defines.svh"
package dsp_pkg;
   typedef enum logic [1:0] {MODE_SIMPLE, MODE_ACC, MODE_ADD2, MODE_ADD4} mode_e;
   typedef enum logic [1:0] {W9, W18, W36} width_e;
   typedef struct packed {
      logic [`NMUL-1:0][`DW-1:0] a_reg;
      logic [`NMUL-1:0][`DW-1:0] b_reg;
      logic [`NMUL-1:0][`PW-1:0] pp_reg;
      logic [2*`NMUL-1:0][`QW-1:0] hp_reg;
      logic [1:0] mctl_reg;
      logic [1:0][`CTLW-1:0] actl_reg;
      logic [1:0][`ACCW-1:0] acc_reg;
      logic [1:0] ovf_reg;
      logic [`NLANE-1:0][`DW-1:0] lane_reg;
   } state_s;
endpackage : dsp_pkg

/* chain_source.sv */
// Model of the neighbouring block that feeds the input shift chains
`timescale 1ns/1ps
`default_nettype none
`include "dsp_defines.svh"
module chain_source (
   // Clock
   input wire logic clk,
   // Chain words toward the block
   output logic [`DW-1:0] chain_a,
   output logic [`DW-1:0] chain_b
);
   logic [`DW-1:0] count_reg = 18'h00000;
   // New word every cycle, so a stage that sticks cannot hide behind a repeat
   always @(posedge clk) begin
      count_reg <= #1 count_reg + 18'h00001;
   end
   assign chain_a = count_reg;
   assign chain_b = ~count_reg; // Inverse keeps the coefficient chain distinct
endmodule : chain_source
`default_nettype wire

/* dsp_block_sva.sv */
// Port-level assertions for the multiply/add block
`timescale 1ns/1ps
`default_nettype none
`include "dsp_defines.svh"
module dsp_block_sva (
   // Clock, reset and configuration
   input wire logic clk,
   input wire logic reset,
   input wire dsp_pkg::mode_e mode,
   input wire dsp_pkg::width_e width,
   input wire logic in_shift,
   input wire logic coef_serial,
   // Group controls and chain inputs
   input wire logic [3:0] grp_clear,
   input wire logic [3:0] grp_enable,
   input wire logic [`DW-1:0] shift_in_a,
   input wire logic [`DW-1:0] shift_in_b,
   // Results
   input wire logic [`NLANE-1:0][`DW-1:0] product_output_lane,
   input wire logic [1:0] overflow,
   input wire logic [`DW-1:0] shift_out_a,
   input wire logic [`DW-1:0] shift_out_b
);
   import dsp_pkg::*;
   // One clock domain, so clocking and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // Sample chain running: not frozen, not cleared, not in wide mode
   sequence chain_on;
      in_shift && width != W36 && grp_enable[0] && !grp_clear[0];
   endsequence
   reset_zero_a: assert property (disable iff (1'b0) reset |=>
      product_output_lane == '0 && overflow == 2'h0) else $error("outputs not cleared by reset");
   ovf_only_acc_a: assert property (($past(mode) != MODE_ACC || $past(width) == W36)
      && $past(grp_enable[2]) |-> overflow == 2'h0) else $error("overflow outside accumulate");
   chain_a_four_a: assert property (chain_on [*4] |=>
      shift_out_a == $past(shift_in_a, 4)) else $error("data chain delay wrong");
   chain_b_four_a: assert property ((in_shift && coef_serial && width != W36 && grp_enable[0]
      && !grp_clear[0]) [*4] |=> shift_out_b == $past(shift_in_b, 4)) else $error("coef chain wrong");
   out_hold_a: assert property (!grp_enable[2] && !grp_clear[2] |=>
      $stable(product_output_lane) && $stable(overflow)) else $error("outputs moved while held");
   out_clear_a: assert property (grp_clear[2] |=>
      product_output_lane == '0 && overflow == 2'h0) else $error("outputs not cleared");
   wide_upper_zero_a: assert property ((width == W36 && grp_enable[2]) [*4] |=>
      product_output_lane[7:4] == '0) else $error("wide product spilled into upper lanes");
   acc_top_zero_a: assert property ($past(mode) == MODE_ACC && $past(width) != W36
      && $past(grp_enable[2]) |-> product_output_lane[2][17:16] == 2'h0
      && product_output_lane[6][17:16] == 2'h0) else $error("accumulator wider than 52 bits");
   // Main scenarios reached
   cover property (chain_on [*4]);
   cover property (!grp_enable[2] ##1 grp_clear[2]);
   cover property ((width == W36) [*4]);
endmodule : dsp_block_sva
bind dsp_block dsp_block_sva chk_u (.clk, .reset, .mode, .width, .in_shift, .coef_serial,
   .grp_clear, .grp_enable, .shift_in_a, .shift_in_b, .product_output_lane, .overflow,
   .shift_out_a, .shift_out_b);
`default_nettype wire

/* test_dsp_multiply_add_block_modes.sv */
// Self-checking bench for the multiply/add block with queued expectations
`timescale 1ns/1ps
`default_nettype none
`include "dsp_defines.svh"
module test_dsp_multiply_add_block_modes;
   import dsp_pkg::*;
   typedef logic [`NLANE-1:0][`DW-1:0] lanes_t;
   typedef struct {int cyc; lanes_t val; lanes_t msk; logic [1:0] ovf;} note_s;
   localparam lanes_t mask_six = {18'h0, {3{18'h3FFFF}}, 18'h0, {3{18'h3FFFF}}};
   logic clk = 1'b0;
   logic reset = 1'b1;
   mode_e mode = MODE_SIMPLE;
   width_e width = W18;
   logic in_shift = 1'b0;
   logic coef_serial = 1'b0;
   logic sign_a = 1'b0;
   logic sign_b = 1'b0;
   logic [1:0] add_sub = 2'h3;
   logic [1:0] acc_load = 2'h0;
   logic [3:0] grp_clear = 4'h0;
   logic [3:0] grp_enable = 4'hF;
   logic pipe_on = 1'b0;
   logic [1:0] add_stg = 2'h1;
   logic [1:0] ovf_want = 2'h0;
   int lat = 2;
   logic [`NMUL-1:0][`DW-1:0] a_in = '0;
   logic [`NMUL-1:0][`DW-1:0] b_in = '0;
   logic [`DW-1:0] sh_a;
   logic [`DW-1:0] sh_b;
   lanes_t lanes;
   logic [1:0] overflow;
   int mismatches = 0;
   int tests_run = 0;
   int cyc = 0;
   note_s notes[$];
   note_s n;
   // Input and output registers always; the product stage adds one edge when switched on
   dsp_block dut_u (.clk(clk), .reset(reset), .mode(mode), .width(width), .in_reg_en(1'b1),
      .in_shift(in_shift), .coef_serial(coef_serial), .pipe_reg_en(pipe_on),
      .ctl_mult_stage(1'b1), .ctl_add_stages(add_stg), .sign_a(sign_a), .sign_b(sign_b),
      .add_sub(add_sub), .acc_load(acc_load), .grp_clear(grp_clear), .grp_enable(grp_enable),
      .a_in(a_in), .b_in(b_in), .shift_in_a(sh_a), .shift_in_b(sh_b),
      .product_output_lane(lanes), .overflow(overflow), .shift_out_a(), .shift_out_b());
   chain_source src_u (.clk(clk), .chain_a(sh_a), .chain_b(sh_b));
   // Full-precision product, signed when either operand is signed
   function automatic logic [35:0] prod(input logic [17:0] a, input logic [17:0] b);
      logic signed [73:0] r;
      r = $signed({sign_a & a[17], a}) * $signed({sign_b & b[17], b});
      return r[35:0];
   endfunction : prod
   task automatic check(input lanes_t seen, input lanes_t want);
      tests_run++;
      if (seen !== want) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic finish_test();
      if (mismatches == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   // Note the result due lat edges on, then move past the next edge
   task automatic step(input lanes_t val, input lanes_t msk);
      notes.push_back('{cyc + lat, val, msk, ovf_want});
      @(posedge clk);
      #1;
   endtask : step
   // Idle edges first, so the last result leaves under the old mode
   task automatic setup(input mode_e m, input width_e w, input logic [1:0] sg);
      repeat (lat - 1) @(posedge clk);
      #1;
      mode = m;
      width = w;
      {sign_a, sign_b} = sg;
   endtask : setup
   initial begin
      forever #25 clk = ~clk;
   end
   // Cycle count and hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 600) begin
         mismatches++;
         finish_test();
      end
   end
   // Take the oldest note once its result is due and compare
   always @(posedge clk) begin
      #2;
      if (notes.size() > 0 && notes[0].cyc == cyc) begin
         n = notes.pop_front();
         check(lanes & n.msk, n.val & n.msk);
         check(lanes_t'(overflow), lanes_t'(n.ovf));
      end
   end
   initial begin
      lanes_t e;
      logic [1:0][51:0] acc;
      logic [51:0] p;
      logic signed [1:0][53:0] s;
      logic [52:0] w;
      logic [3:0][35:0] q;
      lanes_t mk;
      void'($urandom(32'h4eb1e2bb));
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      // Four independent products per step at 18 bits, eight at 9 bits; every sign combination at 18 bits, unsigned only at 9 bits
      for (int t = 0; t < 24; t++) begin
         if (t % 4 == 0) setup(MODE_SIMPLE, (t < 16) ? W18 : W9, (t < 16) ? 2'(t / 4) : 2'h0);
         for (int i = 0; i < 4; i++) begin
            a_in[i] = 18'($urandom);
            b_in[i] = 18'($urandom);
            {e[2*i+1], e[2*i]} = prod(a_in[i], b_in[i]);
            if (width == W9) e[2*i] = a_in[i][8:0] * b_in[i][8:0];
            if (width == W9) e[2*i+1] = a_in[i][17:9] * b_in[i][17:9];
         end
         step(e, '1);
      end
      // Wide product; the chain request must be ignored here
      setup(MODE_ACC, W36, 2'h0);
      in_shift = 1'b1;
      for (int t = 0; t < 8; t++) begin
         // Second half: signed, through the product stage, two adder-control stages
         if (t == 4) begin
            setup(MODE_ACC, W36, 2'h3);
            pipe_on = 1'b1;
            add_stg = 2'h2;
            lat = 3;
         end
         for (int i = 0; i < 4; i++) a_in[i] = 18'($urandom);
         for (int i = 0; i < 4; i++) b_in[i] = 18'($urandom);
         e = '0;
         e[3:0] = (t < 4) ? 72'({a_in[1], a_in[0]} * {b_in[1], b_in[0]})
                : 72'($signed({a_in[1], a_in[0]}) * $signed({b_in[1], b_in[0]}));
         step(e, '1);
      end
      // Load, accumulate two products, then subtract five more, checking the borrow flag each step
      setup(MODE_ACC, W18, 2'h0);
      pipe_on = 1'b0;
      add_stg = 2'h1;
      lat = 2;
      in_shift = 1'b0;
      for (int j = 0; j < 8; j++) begin
         acc_load = (j == 0) ? 2'h3 : 2'h0;
         add_sub = (j > 2) ? 2'h0 : 2'h3;
         e = '0;
         for (int k = 0; k < 2; k++) begin
            a_in[2*k+1] = 18'($urandom);
            b_in[2*k+1] = 18'($urandom);
            p = 52'(prod(a_in[2*k+1], b_in[2*k+1]));
            w = (j == 0) ? {1'b0, p} : (j > 2) ? {1'b0, acc[k]} - {1'b0, p}
                                               : {1'b0, acc[k]} + {1'b0, p};
            ovf_want[k] = (j == 0) ? 1'b0 : w[52];
            acc[k] = w[51:0];
            e[4*k+2 -: 3] = 54'(acc[k]);
         end
         step(e, mask_six);
      end
      ovf_want = 2'h0;
      // Pair sums with one subtracting pair, then the four-product sum
      for (int t = 0; t < 8; t++) begin
         if (t % 4 == 0) setup((t < 4) ? MODE_ADD2 : MODE_ADD4, W18, 2'h3);
         add_sub = 2'h1;
         for (int i = 0; i < 4; i++) a_in[i] = 18'($urandom);
         for (int i = 0; i < 4; i++) b_in[i] = 18'($urandom);
         for (int k = 0; k < 2; k++) begin
            s[k] = 54'($signed(prod(a_in[2*k], b_in[2*k])));
            p = 52'(prod(a_in[2*k+1], b_in[2*k+1]));
            s[k] = add_sub[k] ? s[k] + 54'($signed(p[35:0])) : s[k] - 54'($signed(p[35:0]));
         end
         e = '0;
         e[2:0] = (mode == MODE_ADD4) ? s[0] + s[1] : s[0];
         e[6:4] = s[1];
         step(e, (mode == MODE_ADD4) ? lanes_t'(mask_six[2:0]) : mask_six);
      end
      // Nine-bit pair sums and four-product sums, pair one subtracting
      for (int t = 0; t < 4; t++) begin
         if (t % 2 == 0) setup((t < 2) ? MODE_ADD2 : MODE_ADD4, W9, 2'h0);
         add_sub = 2'h1;
         for (int i = 0; i < 4; i++) a_in[i] = 18'($urandom);
         for (int i = 0; i < 4; i++) b_in[i] = 18'($urandom);
         for (int j = 0; j < 4; j++) begin
            q[j] = 36'(a_in[2*(j/2)][9*(j%2) +: 9] * b_in[2*(j/2)][9*(j%2) +: 9]);
            p = 52'(36'(a_in[2*(j/2)+1][9*(j%2) +: 9] * b_in[2*(j/2)+1][9*(j%2) +: 9]));
            q[j] = add_sub[j/2] ? q[j] + p[35:0] : q[j] - p[35:0];
         end
         e = '0;
         mk = '1;
         if (mode == MODE_ADD2) begin
            for (int j = 0; j < 4; j++) e[2*j+1 -: 2] = q[j];
         end else begin
            e[1:0] = q[0] + q[1];
            e[5:4] = q[2] + q[3];
            mk = '0;
            mk[1:0] = '1;
            mk[5:4] = '1;
         end
         step(e, mk);
      end
      // Serial then parallel coefficient loading on the chains
      in_shift = 1'b1;
      coef_serial = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      coef_serial = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      // Outputs held, then cleared, while operands keep moving
      in_shift = 1'b0;
      grp_enable[2] = 1'b0;
      for (int t = 0; t < 4; t++) begin
         a_in[0] = 18'($urandom);
         if (t == 3) begin
            grp_clear[2] = 1'b1;
            notes.push_back('{cyc + 1, '0, '1, 2'h0}); // Cleared lanes due next edge
         end
         @(posedge clk);
         #1;
      end
      grp_clear[2] = 1'b0;
      grp_enable[2] = 1'b1;
      repeat (4) @(posedge clk);
      if (notes.size() != 0) mismatches++;
      finish_test();
   end
endmodule : test_dsp_multiply_add_block_modes
`default_nettype wire
